// ---- logic/ddc_dual_dac_ctrl.sv ----
// Dual converter control: holding data, triggers, DMA requests, underrun
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Three-bit select picks timer, external line or software trigger when enabled.
// - Writing a channel's software trigger bit produces a software trigger.
// - Trigger enabled: holding data moves to output only on selected trigger.
// - Trigger disabled: holding data moves to output automatically.
// - Concurrent write with triggers off updates both outputs one cycle later.
// - Triggered holding value reaches output three cycles after trigger.
// - DMA request needs trigger and DMA enable; hardware triggers only.
// - DMA enable acts only while trigger enable is set.
// - Trigger while request pending and not acknowledged adds no request, keeps the pending one and sets underrun flag.
// - Interrupt when underrun flag and its enable are both set.
// - After underrun, requests stall until software clears the flag.
// - Each channel with DMA enable raises its own request.
// - One concurrent holding write loads both channels' holding data.
// - Per-channel holding registers keep working beside concurrent ones.
// - Independent triggers: each channel transfers only on its own trigger.
// - Shared trigger rising edge updates both outputs three cycles later.
// - Channel 0 control bits at 0,1,2,5:3,12,13.
// - Channel 1 control bits sit sixteen positions higher.
// - Buffer disable 0 keeps buffer on, 1 turns it off.
// - Channel enable bit powers the converter; resets to zero.
// - Software trigger register at 0x04, write-only, bit per channel.
// - Software trigger bits clear themselves one cycle after the write, acted upon or not.
// - 8-bit right fills 11:4, 12-bit right 11:0, left uses 15:4.
// - Underrun flag set by hardware, cleared by writing one.
module ddc_dual_dac_ctrl (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    // Register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // Trigger sources, asynchronous to this clock
    input  wire logic        i_timer_five_trigger_out,
    input  wire logic        i_timer_two_trigger_out,
    input  wire logic        i_timer_fourteen_trigger_out,
    input  wire logic        i_timer_one_trigger_out,
    input  wire logic        i_external_line_nine,
    // DMA handshake, one per channel
    output logic      [1:0]  o_dma_req,
    input  wire logic [1:0]  i_dma_ack,
    // Converter side
    output logic      [11:0] o_chan0_data,
    output logic      [11:0] o_chan1_data,
    output logic      [1:0]  o_power_on,
    output logic      [1:0]  o_buffer_on,
    output logic             o_irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] ctl;
        logic [1:0]  swt;
        logic [11:0] hold0;
        logic [11:0] hold1;
        logic [11:0] out0;
        logic [11:0] out1;
        // Automatic copy pending, one bit per channel
        logic [1:0]  pend_auto;
        // Delay lines from trigger to output register
        logic [ddc_pkg::TRIG_LAT_CYC-2:0] pipe0;
        logic [ddc_pkg::TRIG_LAT_CYC-2:0] pipe1;
        // DMA underrun flags and pending requests
        logic [1:0]  undr;
        logic [1:0]  req;
        // Two synchroniser stages and edge history of the trigger inputs
        logic [4:0]  sync1;
        logic [4:0]  sync2;
        logic [4:0]  sync_old;
        // Registered read data
        logic [31:0] rdata;
    } ddc_state_s;

    ddc_state_s st_reg;
    ddc_state_s st_next;

    localparam ddc_state_s ST_RESET = '{
        ctl:       ddc_pkg::RST_CTL,
        swt:       2'h0,
        hold0:     ddc_pkg::RST_DATA,
        hold1:     ddc_pkg::RST_DATA,
        out0:      ddc_pkg::RST_DATA,
        out1:      ddc_pkg::RST_DATA,
        pend_auto: 2'h0,
        pipe0:     '0,
        pipe1:     '0,
        undr:      2'h0,
        req:       2'h0,
        sync1:     5'h00,
        sync2:     5'h00,
        sync_old:  5'h00,
        rdata:     32'h0000_0000
    };

    // ------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------
    logic [4:0] src_rise;
    logic [1:0] trig_en;
    logic [1:0] dma_en;
    logic [1:0] undr_ie;
    logic [1:0] hw_trig;
    logic [1:0] sw_trig;
    logic [1:0] fire;
    logic [2:0] sel [2];

    always_comb begin
        // Rising edges taken from the second synchroniser stage only
        src_rise = st_reg.sync2 & ~st_reg.sync_old;
        for (int c = 0; c < 2; c++) begin
            trig_en[c] = st_reg.ctl[c*ddc_pkg::CHAN_STRIDE
                                    + ddc_pkg::POS_TRIG_EN];
            dma_en[c]  = st_reg.ctl[c*ddc_pkg::CHAN_STRIDE
                                    + ddc_pkg::POS_DMA_EN];
            undr_ie[c] = st_reg.ctl[c*ddc_pkg::CHAN_STRIDE
                                    + ddc_pkg::POS_UNDR_IE];
            sel[c]     = st_reg.ctl[c*ddc_pkg::CHAN_STRIDE
                                    + ddc_pkg::POS_TRIG_SEL +: 3];
            hw_trig[c] = 1'b0;
            sw_trig[c] = 1'b0;
            unique case (sel[c])
                ddc_pkg::SEL_TIMER5:  hw_trig[c] = src_rise[0];
                ddc_pkg::SEL_TIMER2:  hw_trig[c] = src_rise[1];
                ddc_pkg::SEL_TIMER14: hw_trig[c] = src_rise[2];
                ddc_pkg::SEL_TIMER1:  hw_trig[c] = src_rise[3];
                ddc_pkg::SEL_EXTLINE: hw_trig[c] = src_rise[4];
                ddc_pkg::SEL_SOFT:    sw_trig[c] = st_reg.swt[c];
                default: begin
                    // Reserved codes stay silent
                    hw_trig[c] = 1'b0;
                end
            endcase
            hw_trig[c] = hw_trig[c] & trig_en[c];
            sw_trig[c] = sw_trig[c] & trig_en[c];
            fire[c]    = hw_trig[c] | sw_trig[c];
        end
    end

    // ------------------------------------------------------------
    // Control write mask
    // ------------------------------------------------------------
    // Reserved control bits are not stored, so they always read as zero
    logic [31:0] ctl_wmask;

    always_comb begin
        ctl_wmask = 32'h0000_0000;
        for (int c = 0; c < 2; c++) begin
            ctl_wmask[c*ddc_pkg::CHAN_STRIDE
                      + ddc_pkg::POS_POWER]     = 1'b1;
            ctl_wmask[c*ddc_pkg::CHAN_STRIDE
                      + ddc_pkg::POS_BUF_OFF]   = 1'b1;
            ctl_wmask[c*ddc_pkg::CHAN_STRIDE
                      + ddc_pkg::POS_TRIG_EN]   = 1'b1;
            ctl_wmask[c*ddc_pkg::CHAN_STRIDE
                      + ddc_pkg::POS_TRIG_SEL +: 3] = 3'h7;
            ctl_wmask[c*ddc_pkg::CHAN_STRIDE
                      + ddc_pkg::POS_DMA_EN]    = 1'b1;
            ctl_wmask[c*ddc_pkg::CHAN_STRIDE
                      + ddc_pkg::POS_UNDR_IE]   = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // Trigger pulses shorter than one clock may be missed
        st_next.sync1    = {i_external_line_nine,
                            i_timer_one_trigger_out,
                            i_timer_fourteen_trigger_out,
                            i_timer_two_trigger_out,
                            i_timer_five_trigger_out};
        st_next.sync2    = st_reg.sync1;
        st_next.sync_old = st_reg.sync2;

        // Trigger pipeline gives a fixed three-cycle transfer latency:
        // the output register write itself is the third cycle after fire
        st_next.pipe0 = {st_reg.pipe0[ddc_pkg::TRIG_LAT_CYC-3:0],
                         fire[0]};
        st_next.pipe1 = {st_reg.pipe1[ddc_pkg::TRIG_LAT_CYC-3:0],
                         fire[1]};
        if (st_reg.pipe0[ddc_pkg::TRIG_LAT_CYC-2]) begin
            st_next.out0 = st_reg.hold0;
        end
        if (st_reg.pipe1[ddc_pkg::TRIG_LAT_CYC-2]) begin
            st_next.out1 = st_reg.hold1;
        end

        // Automatic transfer, one cycle after the holding write.
        // Trigger enable is looked at when the copy is due, so setting it
        // in the cycle after a holding write comes too late to hold the copy back.
        if (st_reg.pend_auto[0] && !trig_en[0]) begin
            st_next.out0 = st_reg.hold0;
        end
        if (st_reg.pend_auto[1] && !trig_en[1]) begin
            st_next.out1 = st_reg.hold1;
        end
        st_next.pend_auto = 2'h0;

        // Software trigger bits self-clear one cycle after the write, consumed or not
        st_next.swt = 2'h0;

        // DMA request and underrun, per channel
        for (int c = 0; c < 2; c++) begin
            if (i_dma_ack[c]) begin
                st_next.req[c] = 1'b0;
            end
            // An acknowledge beside a new trigger frees the slot first, so
            // that trigger becomes the next request rather than an underrun.
            // Only hardware triggers, and only with trigger enable set
            if (hw_trig[c] && dma_en[c] && !st_reg.undr[c]) begin
                if (st_reg.req[c] && !i_dma_ack[c]) begin
                    st_next.undr[c] = 1'b1;
                end else begin
                    st_next.req[c] = 1'b1;
                end
            end
        end

        // Register writes
        if (i_wr) begin
            unique case (i_addr)
                ddc_pkg::OFF_CTL: begin
                    st_next.ctl = i_wdata & ctl_wmask;
                end
                ddc_pkg::OFF_SWT: st_next.swt = i_wdata[1:0];
                ddc_pkg::OFF_C0_R12: begin
                    st_next.hold0 = i_wdata[11:0];
                    st_next.pend_auto[0] = 1'b1;
                end
                ddc_pkg::OFF_C0_L12: begin
                    st_next.hold0 = i_wdata[15:4];
                    st_next.pend_auto[0] = 1'b1;
                end
                ddc_pkg::OFF_C0_R8: begin
                    st_next.hold0 = {i_wdata[7:0], 4'h0};
                    st_next.pend_auto[0] = 1'b1;
                end
                ddc_pkg::OFF_C1_R12: begin
                    st_next.hold1 = i_wdata[11:0];
                    st_next.pend_auto[1] = 1'b1;
                end
                ddc_pkg::OFF_C1_L12: begin
                    st_next.hold1 = i_wdata[15:4];
                    st_next.pend_auto[1] = 1'b1;
                end
                ddc_pkg::OFF_C1_R8: begin
                    st_next.hold1 = {i_wdata[7:0], 4'h0};
                    st_next.pend_auto[1] = 1'b1;
                end
                ddc_pkg::OFF_DUAL_R12: begin
                    st_next.hold0 = i_wdata[11:0];
                    st_next.hold1 = i_wdata[27:16];
                    st_next.pend_auto = 2'h3;
                end
                ddc_pkg::OFF_DUAL_L12: begin
                    st_next.hold0 = i_wdata[15:4];
                    st_next.hold1 = i_wdata[31:20];
                    st_next.pend_auto = 2'h3;
                end
                ddc_pkg::OFF_DUAL_R8: begin
                    st_next.hold0 = {i_wdata[7:0], 4'h0};
                    st_next.hold1 = {i_wdata[15:8], 4'h0};
                    st_next.pend_auto = 2'h3;
                end
                ddc_pkg::OFF_STAT: begin
                    // Write one clears, but a same-cycle underrun wins
                    for (int c = 0; c < 2; c++) begin
                        if (i_wdata[c*ddc_pkg::CHAN_STRIDE
                                    + ddc_pkg::POS_UNDR_FLAG]
                            && st_next.undr[c] == st_reg.undr[c]) begin
                            st_next.undr[c] = 1'b0;
                        end
                    end
                end
                default: st_next.ctl = st_reg.ctl;
            endcase
        end

        // Register reads, data valid the next cycle only
        st_next.rdata = 32'h0000_0000;
        if (i_rd) begin
            unique case (i_addr)
                ddc_pkg::OFF_CTL:      st_next.rdata = st_reg.ctl;
                ddc_pkg::OFF_C0_R12:   st_next.rdata = {20'h0, st_reg.hold0};
                ddc_pkg::OFF_C0_L12:   st_next.rdata = {16'h0, st_reg.hold0,
                                                        4'h0};
                ddc_pkg::OFF_C0_R8:    st_next.rdata = {24'h0,
                                                        st_reg.hold0[11:4]};
                ddc_pkg::OFF_C1_R12:   st_next.rdata = {20'h0, st_reg.hold1};
                ddc_pkg::OFF_C1_L12:   st_next.rdata = {16'h0, st_reg.hold1,
                                                        4'h0};
                ddc_pkg::OFF_C1_R8:    st_next.rdata = {24'h0,
                                                        st_reg.hold1[11:4]};
                ddc_pkg::OFF_DUAL_R12: st_next.rdata = {4'h0, st_reg.hold1,
                                                        4'h0, st_reg.hold0};
                ddc_pkg::OFF_DUAL_L12: st_next.rdata = {st_reg.hold1, 4'h0,
                                                        st_reg.hold0, 4'h0};
                ddc_pkg::OFF_DUAL_R8:  st_next.rdata = {16'h0,
                                                        st_reg.hold1[11:4],
                                                        st_reg.hold0[11:4]};
                ddc_pkg::OFF_C0_OUT:   st_next.rdata = {20'h0, st_reg.out0};
                ddc_pkg::OFF_C1_OUT:   st_next.rdata = {20'h0, st_reg.out1};
                ddc_pkg::OFF_STAT: begin
                    st_next.rdata[ddc_pkg::POS_UNDR_FLAG] = st_reg.undr[0];
                    st_next.rdata[ddc_pkg::CHAN_STRIDE
                                  + ddc_pkg::POS_UNDR_FLAG] =
                        st_reg.undr[1];
                end
                // Write-only trigger register and holes read as zero
                default:               st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata      = st_reg.rdata;
    assign o_dma_req    = st_reg.req;
    assign o_chan0_data = st_reg.out0;
    assign o_chan1_data = st_reg.out1;
    assign o_power_on   = {st_reg.ctl[ddc_pkg::CHAN_STRIDE
                                      + ddc_pkg::POS_POWER],
                           st_reg.ctl[ddc_pkg::POS_POWER]};
    assign o_buffer_on  = ~{st_reg.ctl[ddc_pkg::CHAN_STRIDE
                                       + ddc_pkg::POS_BUF_OFF],
                            st_reg.ctl[ddc_pkg::POS_BUF_OFF]};
    // Interrupt is a level that stays up until software clears the flag or its enable
    assign o_irq        = |(st_reg.undr & undr_ie);
endmodule
`default_nettype wire

// ---- logic/ddc_pkg.sv ----
// Package: register map, field positions and timing of the dual converter control
package ddc_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CTL      = 8'h00;
    localparam logic [7:0] OFF_SWT      = 8'h04;
    localparam logic [7:0] OFF_C0_R12   = 8'h08;
    localparam logic [7:0] OFF_C0_L12   = 8'h0c;
    localparam logic [7:0] OFF_C0_R8    = 8'h10;
    localparam logic [7:0] OFF_C1_R12   = 8'h14;
    localparam logic [7:0] OFF_C1_L12   = 8'h18;
    localparam logic [7:0] OFF_C1_R8    = 8'h1c;
    localparam logic [7:0] OFF_DUAL_R12 = 8'h20;
    localparam logic [7:0] OFF_DUAL_L12 = 8'h24;
    localparam logic [7:0] OFF_DUAL_R8  = 8'h28;
    localparam logic [7:0] OFF_C0_OUT   = 8'h2c;
    localparam logic [7:0] OFF_C1_OUT   = 8'h30;
    localparam logic [7:0] OFF_STAT     = 8'h34;
    // Control field positions within one channel half
    localparam int POS_POWER      = 0;
    localparam int POS_BUF_OFF    = 1;
    localparam int POS_TRIG_EN    = 2;
    localparam int POS_TRIG_SEL   = 3;
    localparam int POS_DMA_EN     = 12;
    localparam int POS_UNDR_IE    = 13;
    localparam int POS_UNDR_FLAG  = 13;
    localparam int CHAN_STRIDE    = 16;
    // Reset values
    localparam logic [31:0] RST_CTL  = 32'h0000_0000;
    localparam logic [11:0] RST_DATA = 12'h000;
    // Trigger selection codes
    localparam logic [2:0] SEL_TIMER5  = 3'h0;
    localparam logic [2:0] SEL_TIMER2  = 3'h1;
    localparam logic [2:0] SEL_TIMER14 = 3'h3;
    localparam logic [2:0] SEL_TIMER1  = 3'h4;
    localparam logic [2:0] SEL_EXTLINE = 3'h6;
    localparam logic [2:0] SEL_SOFT    = 3'h7;
    // Timing: triggered transfer latency and concurrent write latency
    localparam int TRIG_LAT_CYC = 3;
    localparam int AUTO_LAT_CYC = 1;
endpackage

// ---- verif/ddc_dma_partner.sv ----
// DMA controller model: acknowledges each request after a set delay
`timescale 1ns/1ps
`default_nettype none
module ddc_dma_partner (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    // Requests in; delay 8'hff means never answer
    input  wire logic [1:0] i_dma_req,
    input  wire logic [7:0] i_delay,
    output logic      [1:0] o_dma_ack
);
    logic [7:0] cnt [2];
    always_ff @(posedge i_ref_clk) begin
        for (int c = 0; c < 2; c++) begin
            o_dma_ack[c] <= 1'b0;
            if (!i_rst_b || !i_dma_req[c] || o_dma_ack[c]) begin
                cnt[c] <= 8'h00;
            end else if (cnt[c] >= i_delay && i_delay != 8'hff) begin
                o_dma_ack[c] <= 1'b1;
            end else begin
                cnt[c] <= cnt[c] + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/ddc_dual_dac_ctrl_properties.sv ----
// Checker: port-level timing of the dual converter control
`timescale 1ns/1ps
`default_nettype none
module ddc_dual_dac_ctrl_checker (
    // Clock, reset and register port
    input wire logic        i_ref_clk,
    input wire logic        i_rst_b,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    // DMA and converter side
    input wire logic [1:0]  o_dma_req,
    input wire logic [1:0]  i_dma_ack,
    input wire logic [11:0] o_chan0_data,
    input wire logic [11:0] o_chan1_data,
    input wire logic [1:0]  o_power_on,
    input wire logic [1:0]  o_buffer_on,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // Shadow of control and channel 0 holding data, seen from the bus
    logic [31:0] ctl_reg;
    logic [11:0] h0_reg;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            ctl_reg <= 32'h0;
            h0_reg  <= 12'h0;
        end else if (i_wr) begin
            case (i_addr)
                8'h00: ctl_reg <= i_wdata;
                8'h08, 8'h20: h0_reg <= i_wdata[11:0];
                8'h0c, 8'h24: h0_reg <= i_wdata[15:4];
                8'h10, 8'h28: h0_reg <= {i_wdata[7:0], 4'h0};
                default: ;
            endcase
        end
    end
    sequence s_swt0;
        i_wr && i_addr == 8'h04 && i_wdata[0] && ctl_reg[5:2] == 4'hf;
    endsequence
    sequence s_hold0; $stable(o_chan0_data) [*3]; endsequence
    property p_pwr;
        {o_buffer_on, o_power_on} ==
            {~ctl_reg[17], ~ctl_reg[1], ctl_reg[16], ctl_reg[0]};
    endproperty
    property p_irq; o_irq |-> ctl_reg[13] || ctl_reg[29]; endproperty
    property p_rdz; !i_rd |=> o_rdata == 32'h0; endproperty
    property p_swtz; i_rd && i_addr == 8'h04 |=> o_rdata == 32'h0; endproperty
    property p_ctlrd;
        i_rd && i_addr == 8'h00 |=> o_rdata == (ctl_reg & 32'h303f_303f);
    endproperty
    property p_auto;
        i_wr && i_addr == 8'h20 && !ctl_reg[2] && !ctl_reg[18] |=> ##1
            o_chan0_data == $past(i_wdata[11:0], 2) &&
            o_chan1_data == $past(i_wdata[27:16], 2);
    endproperty
    property p_swtlat; s_swt0 |=> s_hold0 ##1 o_chan0_data == h0_reg; endproperty
    property p_reqc;
        $rose(o_dma_req[0]) |-> ctl_reg[2] && ctl_reg[12] &&
            ctl_reg[5:3] inside {3'h0, 3'h1, 3'h3, 3'h4, 3'h6};
    endproperty
    property p_fall; $fell(o_dma_req[0]) |-> $past(i_dma_ack[0]); endproperty
    a_pwr: assert property (p_pwr) else $error("enable bits wrong");
    a_irq: assert property (p_irq) else $error("irq unmasked");
    a_rdz: assert property (p_rdz) else $error("read data not idle");
    a_swtz: assert property (p_swtz) else $error("trigger reg read");
    a_ctlrd: assert property (p_ctlrd) else $error("ctl readback");
    a_auto: assert property (p_auto) else $error("auto update");
    a_swtlat: assert property (p_swtlat) else $error("soft latency");
    a_reqc: assert property (p_reqc) else $error("bad dma request");
    a_fall: assert property (p_fall) else $error("req dropped");
endmodule
bind ddc_dual_dac_ctrl ddc_dual_dac_ctrl_checker u_chk (.i_ref_clk, .i_rst_b,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_dma_req, .i_dma_ack,
    .o_chan0_data, .o_chan1_data, .o_power_on, .o_buffer_on, .o_irq);
`default_nettype wire

// ---- verif/ddc_dual_dac_ctrl_test.sv ----
// Testbench: registers, triggers and DMA of the dual converter control
`timescale 1ns/1ps
`default_nettype none
module ddc_dual_dac_ctrl_test;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [4:0]  trg = 5'h00;
    logic [7:0]  dly = 8'h02;
    logic [1:0]  seen = 2'b00;
    logic [11:0] e1 = 12'hb20;
    wire  [31:0] rdata;
    wire  [1:0]  req, ack, pwr, buf_on;
    wire  [11:0] d0, d1;
    wire         irq;
    int          n_mismatch = 0;
    int          comparisons = 0;
    // Address, write data, expected channel 0 and channel 1 outputs
    logic [63:0] tab [9] = '{64'h20_0abc0123_123_abc, 64'h24_567089a0_89a_567,
        64'h28_0000c3d4_d40_c30, 64'h08_00000fed_fed_c30,
        64'h0c_00007650_765_c30, 64'h10_000000a1_a10_c30,
        64'h14_00000321_a10_321, 64'h18_00004560_a10_456,
        64'h1c_000000b2_a10_b20};
    ddc_dual_dac_ctrl dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_timer_five_trigger_out(trg[0]), .i_timer_two_trigger_out(trg[1]),
        .i_timer_fourteen_trigger_out(trg[2]),
        .i_timer_one_trigger_out(trg[3]), .i_external_line_nine(trg[4]),
        .o_dma_req(req), .i_dma_ack(ack), .o_chan0_data(d0),
        .o_chan1_data(d1), .o_power_on(pwr), .o_buffer_on(buf_on),
        .o_irq(irq));
    ddc_dma_partner dma (.i_ref_clk(clk), .i_rst_b(rst_b), .i_dma_req(req),
        .i_delay(dly), .o_dma_ack(ack));
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) seen <= seen | req;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    // Hold the source high and low long enough for the synchroniser
    task automatic pulse(input logic [4:0] m);
        @(posedge clk);
        trg <= m;
        repeat (4) @(posedge clk);
        trg <= 5'h00;
        cyc(8);
    endtask
    task automatic end_sim();
        $display("comparisons %0d, n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        $display("MISMATCH at %0t: run limit reached", $time);
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        cyc(1);
        chk(buf_on, 2'b11);
        chk(pwr, 2'b00);
        rdc(8'h04, 32'h0);
        rdc(8'h3c, 32'h0);
        wreg(8'h00, 32'h0003_0001);
        chk({buf_on, pwr}, 4'b0111);
        rdc(8'h00, 32'h0003_0001);
        $display("test registers done");
        foreach (tab[i]) begin
            wreg(tab[i][63:56], tab[i][55:24]);
            cyc(1);
            chk(d0, tab[i][23:12]);
            chk(d1, tab[i][11:0]);
        end
        rdc(8'h2c, 32'h0000_0a10);
        $display("test holding done");
        // Channel 1 walks the hardware sources, channel 0 waits on software
        for (int i = 0; i < 5; i++) begin
            wreg(8'h00, {10'h0, 3'(i + i/2), 3'h4, 10'h0, 3'h7, 3'h4});
            wreg(8'h20, {4'h0, e1 ^ 12'h5a5, 4'h0, 12'h3c3});
            cyc(2);
            chk(d1, e1);
            e1 = e1 ^ 12'h5a5;
            pulse(5'h01 << i);
            chk(d1, e1);
            chk(d0, 12'ha10);
        end
        wreg(8'h04, 32'h0000_0001);
        cyc(2);
        chk(d0, 12'ha10);
        cyc(1);
        chk(d0, 12'h3c3);
        wreg(8'h20, 32'h0000_0777);
        cyc(6);
        chk(d0, 12'h3c3);
        for (int r = 2; r < 6; r += 3) begin
            wreg(8'h00, {10'h0, 3'(r), 3'h4, 10'h0, 3'h7, 3'h4});
            pulse(5'h1f);
            chk(d1, e1);
        end
        wreg(8'h00, 32'h003c_003c);
        wreg(8'h14, 32'h0000_05e1);
        wreg(8'h04, 32'h0000_0002);
        cyc(4);
        chk(d1, 12'h5e1);
        chk(d0, 12'h3c3);
        rdc(8'h30, 32'h0000_05e1);
        $display("test triggers done");
        wreg(8'h00, 32'h1034_1034);
        wreg(8'h20, 32'h0123_0456);
        seen = 2'b00;
        pulse(5'h10);
        chk({d1, d0}, 24'h123_456);
        chk(seen, 2'b11);
        wreg(8'h00, 32'h0000_300c);
        dly = 8'hff;
        pulse(5'h02);
        pulse(5'h02);
        rdc(8'h34, 32'h0000_2000);
        chk(irq, 1'b1);
        dly = 8'h00;
        cyc(3);
        seen = 2'b00;
        pulse(5'h02);
        chk(seen, 2'b00);
        wreg(8'h34, 32'h0000_2000);
        rdc(8'h34, 32'h0);
        chk(irq, 1'b0);
        pulse(5'h02);
        chk(seen, 2'b01);
        wreg(8'h00, 32'h0000_103c);
        seen = 2'b00;
        wreg(8'h04, 32'h0000_0001);
        cyc(6);
        chk(seen, 2'b00);
        wreg(8'h00, 32'h0000_1008);
        pulse(5'h02);
        chk(seen, 2'b00);
        $display("test dma done");
        end_sim();
    end
endmodule
`default_nettype wire
